// File: sbc_dev.sv
// Device end: two-wire target with the six-byte control register bank.
// Runs on its own link-side clock, much faster than the wire clock;
// strap pins and the wires are asynchronous and are synchronised here.
`timescale 1ns/1ps
module sbc_dev #(
	parameter logic [3:0] REV_CODE    = 4'h3,  // Arbitrary value
	parameter logic [3:0] VENDOR_CODE = 4'h5,  // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'hA7  // Arbitrary value
) (
	// Clock and reset
	input  wire logic       clk_link,
	input  wire logic       rst,
	// Two-wire link
	sbc_link_if.dev         link,
	// Strap pins for loop settings
	input  wire logic       pin_bw_high,
	input  wire logic       pin_loop_on,
	// Clock path controls
	output logic            loop_bandwidth_select,
	output logic            loop_active,
	output logic [3:0]      out_enable
);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ADDR   = 3'h1,
		ST_INDEX  = 3'h3,
		ST_COUNT  = 3'h2,
		ST_WDATA  = 3'h6,
		ST_TX     = 3'h7,
		ST_IGNORE = 3'h5
	} sbc_dev_st_t;

	sbc_dev_st_t st_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  tx_reg;
	logic [7:0]  idx_reg;
	logic [7:0]  wcnt_reg;
	logic        ack_pend_reg;
	logic        sda_oe_n_reg;

	// Register bank
	logic [7:0]  ctrl_reg;
	logic [7:0]  oe_reg;
	logic [7:0]  fsel_reg;
	logic [7:0]  len_reg;

	// Synchroniser stages
	logic        scl_s1_reg;
	logic        scl_s2_reg;
	logic        scl_s3_reg;
	logic        sda_s1_reg;
	logic        sda_s2_reg;
	logic        sda_s3_reg;
	logic        pin_bw_s1_reg;
	logic        pin_bw_s2_reg;
	logic        pin_loop_s1_reg;
	logic        pin_loop_s2_reg;

	// Output flops
	logic        bw_sel_reg;
	logic        loop_on_reg;
	logic [3:0]  oe_out_reg;

	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        ack_ok;
	logic        wr_en;
	logic [7:0]  rd_byte;

	// Two flops per asynchronous input; third stage only for edges
	always_ff @(posedge clk_link) begin
		if (rst) begin
			scl_s1_reg      <= 1'b1;
			scl_s2_reg      <= 1'b1;
			scl_s3_reg      <= 1'b1;
			sda_s1_reg      <= 1'b1;
			sda_s2_reg      <= 1'b1;
			sda_s3_reg      <= 1'b1;
			pin_bw_s1_reg   <= 1'b1;
			pin_bw_s2_reg   <= 1'b1;
			pin_loop_s1_reg <= 1'b1;
			pin_loop_s2_reg <= 1'b1;
		end else begin
			scl_s1_reg      <= link.scl;
			scl_s2_reg      <= scl_s1_reg;
			scl_s3_reg      <= scl_s2_reg;
			sda_s1_reg      <= link.sda;
			sda_s2_reg      <= sda_s1_reg;
			sda_s3_reg      <= sda_s2_reg;
			pin_bw_s1_reg   <= pin_bw_high;
			pin_bw_s2_reg   <= pin_bw_s1_reg;
			pin_loop_s1_reg <= pin_loop_on;
			pin_loop_s2_reg <= pin_loop_s1_reg;
		end
	end

	// Wire events; data moving while the clock is high marks start or stop
	assign scl_rise  = scl_s2_reg & ~scl_s3_reg;
	assign scl_fall  = ~scl_s2_reg & scl_s3_reg;
	assign start_det = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
	assign stop_det  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

	// Acknowledge own address in either direction, all written bytes after it
	assign ack_ok = ((st_reg == ST_ADDR) && (shift_reg[7:1] == sbc_pkg::DEV_ADDR7))
		|| (st_reg == ST_INDEX)
		|| (st_reg == ST_COUNT)
		|| (st_reg == ST_WDATA);

	// Store a data byte at its ninth clock while the count lasts
	assign wr_en = scl_rise && (bit_cnt_reg == 4'h8) && (st_reg == ST_WDATA)
		&& (wcnt_reg != 8'h00);

	// Readback selection; unused indexes read zero
	always_comb begin
		case (idx_reg)
			sbc_pkg::IDX_CTRL:  rd_byte = ctrl_reg;
			sbc_pkg::IDX_OE:    rd_byte = oe_reg;
			sbc_pkg::IDX_FSEL:  rd_byte = fsel_reg;
			sbc_pkg::IDX_ID:    rd_byte = {REV_CODE, VENDOR_CODE};
			sbc_pkg::IDX_DEVID: rd_byte = DEVICE_CODE;
			sbc_pkg::IDX_LEN:   rd_byte = len_reg;
			default:            rd_byte = 8'h00;
		endcase
	end

	// Transfer sequencing: bits sampled on rising, driven on falling edges
	always_ff @(posedge clk_link) begin
		if (rst) begin
			st_reg       <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'h00;
			idx_reg      <= 8'h00;
			wcnt_reg     <= 8'h00;
			ack_pend_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else if (start_det) begin
			// Repeated start keeps the index from the write phase
			st_reg       <= ST_ADDR;
			bit_cnt_reg  <= 4'h0;
			ack_pend_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else if (stop_det) begin
			st_reg       <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			ack_pend_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else if (st_reg != ST_IDLE) begin
			if (scl_rise) begin
				if (bit_cnt_reg != 4'h8) begin
					shift_reg   <= {shift_reg[6:0], sda_s2_reg};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else begin
					// Ninth clock: acknowledge slot closes, byte is acted on
					bit_cnt_reg  <= 4'h0;
					ack_pend_reg <= 1'b1;
					case (st_reg)
						ST_ADDR: begin
							if (shift_reg[7:1] != sbc_pkg::DEV_ADDR7) begin
								st_reg <= ST_IGNORE;
							end else if (shift_reg[0]) begin
								st_reg <= ST_TX;
								tx_reg <= len_reg;
							end else begin
								st_reg <= ST_INDEX;
							end
						end
						ST_INDEX: begin
							idx_reg <= shift_reg;
							st_reg  <= ST_COUNT;
						end
						ST_COUNT: begin
							wcnt_reg <= shift_reg;
							st_reg   <= ST_WDATA;
						end
						ST_WDATA: begin
							if (wcnt_reg != 8'h00) begin
								idx_reg  <= idx_reg + 8'h01;
								wcnt_reg <= wcnt_reg - 8'h01;
							end
						end
						ST_TX: begin
							// Not-acknowledge from the host ends sending
							if (sda_s2_reg) begin
								st_reg <= ST_IGNORE;
							end else begin
								tx_reg  <= rd_byte;
								idx_reg <= idx_reg + 8'h01;
							end
						end
						default: ;
					endcase
				end
			end else if (scl_fall) begin
				if (ack_pend_reg) begin
					// Release acknowledge; first bit of the next byte when sending
					ack_pend_reg <= 1'b0;
					sda_oe_n_reg <= (st_reg == ST_TX) ? tx_reg[7] : 1'b1;
				end else if (bit_cnt_reg == 4'h8) begin
					// Host owns the acknowledge slot of a sent byte
					sda_oe_n_reg <= (st_reg == ST_TX) ? 1'b1 : ~ack_ok;
				end else if ((st_reg == ST_TX) && (bit_cnt_reg != 4'h0)) begin
					sda_oe_n_reg <= tx_reg[3'(4'h7 - bit_cnt_reg)];
				end
			end
		end
	end

	// Register bank writes; read-only and unused indexes drop the data
	always_ff @(posedge clk_link) begin
		if (rst) begin
			ctrl_reg <= sbc_pkg::CTRL_RESET;
			oe_reg   <= sbc_pkg::OE_RESET;
			fsel_reg <= sbc_pkg::FSEL_RESET;
			len_reg  <= sbc_pkg::LEN_RESET;
		end else if (wr_en) begin
			case (idx_reg)
				sbc_pkg::IDX_CTRL: ctrl_reg <= shift_reg;
				sbc_pkg::IDX_OE:   oe_reg   <= shift_reg;
				sbc_pkg::IDX_FSEL: fsel_reg <= shift_reg;
				sbc_pkg::IDX_LEN:  len_reg  <= shift_reg;
				default: ;
			endcase
		end
	end

	// Loop settings from straps or from register bits
	always_ff @(posedge clk_link) begin
		if (rst) begin
			bw_sel_reg  <= 1'b1;
			loop_on_reg <= 1'b1;
		end else if (ctrl_reg[sbc_pkg::CTRL_PIN_SEL_BIT]) begin
			bw_sel_reg  <= pin_bw_s2_reg;
			loop_on_reg <= pin_loop_s2_reg;
		end else begin
			bw_sel_reg  <= ctrl_reg[sbc_pkg::CTRL_BW_BIT];
			loop_on_reg <= ctrl_reg[sbc_pkg::CTRL_LOOP_BIT];
		end
	end

	// One enable flop per differential output
	genvar g;
	generate
		for (g = 0; g < sbc_pkg::OUT_N; g++) begin : g_oe
			always_ff @(posedge clk_link) begin
				if (rst) begin
					oe_out_reg[g] <= 1'b1;
				end else begin
					oe_out_reg[g] <= oe_reg[sbc_pkg::OUT_BIT[g]];
				end
			end
		end
	endgenerate

	// Open drain: data level stays low, enable does the driving
	assign link.dev_sda_o      = 1'b0;
	assign link.dev_sda_oe_n   = sda_oe_n_reg;
	assign loop_bandwidth_select = bw_sel_reg;
	assign loop_active           = loop_on_reg;
	assign out_enable            = oe_out_reg;

endmodule : sbc_dev

// File: sbc_pkg.sv
// Shared constants for the two-wire buffer-control link: device register
// map, field positions, reset values and host timing and register layout.
// Assumes a 20 MHz system clock on the host end.
// How it works
// - Write starts: start, write address, device acknowledges.
// - Read address after repeated start; acknowledged, device drives.
// - Index byte sets first register location.
// - Write carries byte count, acknowledged by device.
// - Data bytes stored N upward; stop ends.
// - Device acknowledges every written data byte.
// - Host reads via index write, repeated start.
// - Device sends readback length before register data.
// - Then registers from index N onward, bytewise.
// - Host acknowledges each returned byte but the last, count included.
// - Host ends read with not-acknowledge, stop.
// - Control bit 7 chooses pins or register loop settings.
// - Control bit 1 picks loop bandwidth, default high.
// - Control bit 0 bypasses loop when 0, default 1.
// - Enable bits 5,3,2,0 gate outputs, default on.
// - Byte 3 revision/vendor, byte 4 device code, read-only.
// - Byte 5 sets block-read length, default 6.
package sbc_pkg;

	// Link addressing
	localparam logic [6:0] DEV_ADDR7 = 7'h6A;

	// Device register indexes
	localparam logic [7:0] IDX_CTRL  = 8'h00;
	localparam logic [7:0] IDX_OE    = 8'h01;
	localparam logic [7:0] IDX_FSEL  = 8'h02;
	localparam logic [7:0] IDX_ID    = 8'h03;
	localparam logic [7:0] IDX_DEVID = 8'h04;
	localparam logic [7:0] IDX_LEN   = 8'h05;

	// Control byte fields
	localparam int CTRL_PIN_SEL_BIT = 7;
	localparam int CTRL_BW_BIT      = 1;
	localparam int CTRL_LOOP_BIT    = 0;

	// Output enable positions for outputs 0, 2, 3, 5
	localparam int OUT_N = 4;
	localparam int OUT_BIT [0:3] = '{0, 2, 3, 5};

	// Device reset values
	localparam logic [7:0] CTRL_RESET = 8'h83;
	localparam logic [7:0] OE_RESET   = 8'h2D;
	localparam logic [7:0] FSEL_RESET = 8'h00;
	localparam logic [7:0] LEN_RESET  = 8'h06;

	// Host timing: quarter of the wire clock period, rounded up
	localparam int CLK_SYS_NS      = 50;
	localparam int SCL_PERIOD_NS   = 10000;
	localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_SYS_NS - 1) / (4 * CLK_SYS_NS);

	// Host APB register offsets
	localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
	localparam logic [7:0] HOST_STAT_OFS = 8'h04;
	localparam logic [7:0] HOST_BUF_OFS  = 8'h08;

	// Host command and status fields
	localparam int HC_GO      = 0;
	localparam int HC_RD      = 1;
	localparam int HC_IDX_LSB = 8;
	localparam int HC_CNT_LSB = 16;
	localparam int HS_BUSY    = 0;
	localparam int HS_NACK    = 1;
	localparam int HS_DONE    = 2;

endpackage : sbc_pkg

// File: sbc_link_if.sv
// Two-wire link between host and device ends.
// Both wires are open drain with pull-ups; levels resolve from the enables.
`timescale 1ns/1ps
interface sbc_link_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;

	// Wired-and with pull-up
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
		input scl, sda);
	modport dev (output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface : sbc_link_if

// File: sbc_host.sv
// Host end: APB-programmed controller issuing indexed block writes and
// block reads on the two-wire link. Makes the wire clock by division of
// clk_sys; only the returning data wire is synchronised.
`timescale 1ns/1ps
module sbc_host #(
	parameter int unsigned MAX_BYTES   = 8,
	parameter int unsigned QUARTER_CYC = sbc_pkg::SCL_QUARTER_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Two-wire link
	sbc_link_if.host         link
);

	localparam int AW = $clog2(MAX_BYTES);

	typedef enum logic [3:0] {
		H_IDLE = 4'h0, H_START = 4'h1, H_ADDR = 4'h3, H_INDEX = 4'h2,
		H_COUNT = 4'h6, H_WDATA = 4'h7, H_STOP = 4'h5, H_RSTART = 4'h4,
		H_RADDR = 4'hC, H_RCOUNT = 4'hD, H_RDATA = 4'hF
	} sbc_host_st_t;

	sbc_host_st_t st_reg;
	logic [15:0] div_reg;
	logic [1:0]  q_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  sh_reg, idx_reg, cnt_reg, lim_reg, n_reg, xcnt_reg;
	logic        rd_reg, nak_reg, done_reg, nack_reg;
	logic        scl_oe_n_reg, sda_oe_n_reg, sda_s1_reg, sda_s2_reg;
	logic        pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;
	logic [7:0]  buf_mem [MAX_BYTES];

	logic        tick, is_rx, is_tx, byte_end, sda_lvl, rx_nak;
	logic        apb_wr, cmd_go, buf_we, err;
	logic [7:0]  lim_next, boff;
	logic [31:0] rd_word;

	assign tick     = (div_reg == 16'(QUARTER_CYC - 1));
	assign is_rx    = (st_reg == H_RCOUNT) || (st_reg == H_RDATA);
	assign is_tx    = (st_reg == H_ADDR) || (st_reg == H_INDEX) || (st_reg == H_COUNT)
		|| (st_reg == H_WDATA) || (st_reg == H_RADDR);
	assign byte_end = tick && (q_reg == 2'h3) && (bit_reg == 4'h8);
	assign lim_next = (sh_reg < cnt_reg) ? sh_reg : cnt_reg;
	// Not-acknowledge the last wanted byte, or the count if none wanted
	assign rx_nak   = (st_reg == H_RCOUNT) ? (lim_next == 8'h00)
		: ({1'b0, n_reg} + 9'h001 >= {1'b0, lim_reg});
	assign apb_wr   = psel && penable && pready_reg && pwrite;
	assign cmd_go   = apb_wr && (paddr == sbc_pkg::HOST_CTRL_OFS) && pwdata[sbc_pkg::HC_GO];
	assign buf_we   = byte_end && (st_reg == H_RDATA);
	assign boff     = paddr - sbc_pkg::HOST_BUF_OFS;

	// Data wire level at the start of each bit slot
	always_comb begin
		case (st_reg)
			H_START, H_RSTART: sda_lvl = 1'b1;
			H_STOP:            sda_lvl = 1'b0;
			default:           sda_lvl = (bit_reg != 4'h8) ? (is_rx | sh_reg[7])
				: (is_rx ? rx_nak : 1'b1);
		endcase
	end

	// Returning data wire
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
		end else begin
			sda_s1_reg <= link.sda;
			sda_s2_reg <= sda_s1_reg;
		end
	end

	// Symbol engine: four quarters per bit, start or stop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg <= H_IDLE; div_reg <= 16'h0000; q_reg <= 2'h0; bit_reg <= 4'h0;
			sh_reg <= 8'h00; idx_reg <= 8'h00; cnt_reg <= 8'h00; lim_reg <= 8'h00;
			n_reg <= 8'h00; xcnt_reg <= 8'h00; rd_reg <= 1'b0; nak_reg <= 1'b0;
			scl_oe_n_reg <= 1'b1; sda_oe_n_reg <= 1'b1;
		end else if (st_reg == H_IDLE) begin
			div_reg <= 16'h0000;
			q_reg   <= 2'h0;
			bit_reg <= 4'h0;
			if (cmd_go) begin
				st_reg  <= H_START;
				rd_reg  <= pwdata[sbc_pkg::HC_RD];
				idx_reg <= pwdata[sbc_pkg::HC_IDX_LSB +: 8];
				cnt_reg <= (pwdata[sbc_pkg::HC_CNT_LSB +: 8] > 8'(MAX_BYTES)) ? 8'(MAX_BYTES)
					: pwdata[sbc_pkg::HC_CNT_LSB +: 8];
			end
		end else if (!tick) begin
			div_reg <= div_reg + 16'h0001;
		end else begin
			div_reg <= 16'h0000;
			q_reg   <= q_reg + 2'h1;
			case (q_reg)
				2'h0: sda_oe_n_reg <= sda_lvl;
				2'h1: scl_oe_n_reg <= 1'b1;
				2'h2: begin
					nak_reg <= sda_s2_reg;
					if (is_rx && (bit_reg != 4'h8)) sh_reg <= {sh_reg[6:0], sda_s2_reg};
					if ((st_reg == H_START) || (st_reg == H_RSTART)) sda_oe_n_reg <= 1'b0;
					if (st_reg == H_STOP) sda_oe_n_reg <= 1'b1;
				end
				default: begin
					if (st_reg != H_STOP) scl_oe_n_reg <= 1'b0;
					if (st_reg == H_START) begin
						st_reg <= H_ADDR; sh_reg <= {sbc_pkg::DEV_ADDR7, 1'b0};
					end else if (st_reg == H_RSTART) begin
						st_reg <= H_RADDR; sh_reg <= {sbc_pkg::DEV_ADDR7, 1'b1};
					end else if (st_reg == H_STOP) begin
						st_reg <= H_IDLE;
					end else if (bit_reg != 4'h8) begin
						bit_reg <= bit_reg + 4'h1;
						if (is_tx) sh_reg <= {sh_reg[6:0], 1'b0};
					end else begin
						bit_reg <= 4'h0;
						if (is_tx && nak_reg) begin
							st_reg <= H_STOP;
						end else begin
							case (st_reg)
								H_ADDR: begin st_reg <= H_INDEX; sh_reg <= idx_reg; end
								H_INDEX: begin
									if (rd_reg) st_reg <= H_RSTART;
									else begin st_reg <= H_COUNT; sh_reg <= cnt_reg; end
								end
								H_COUNT: begin
									st_reg <= (cnt_reg == 8'h00) ? H_STOP : H_WDATA;
									sh_reg <= buf_mem[0];
									n_reg  <= 8'h00;
								end
								H_WDATA: begin
									if (n_reg + 8'h01 == cnt_reg) st_reg <= H_STOP;
									sh_reg <= buf_mem[AW'(n_reg + 8'h01)];
									n_reg  <= n_reg + 8'h01;
								end
								H_RADDR: st_reg <= H_RCOUNT;
								H_RCOUNT: begin
									xcnt_reg <= sh_reg;
									lim_reg  <= lim_next;
									n_reg    <= 8'h00;
									st_reg   <= (lim_next == 8'h00) ? H_STOP : H_RDATA;
								end
								default: begin
									if (rx_nak) st_reg <= H_STOP;
									n_reg <= n_reg + 8'h01;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// Buffer: APB fills it for writes, link fills it during reads
	always_ff @(posedge clk_sys) begin
		if (buf_we) begin
			buf_mem[AW'(n_reg)] <= sh_reg;
		end else if (apb_wr && (st_reg == H_IDLE) && !err && (paddr >= sbc_pkg::HOST_BUF_OFS)) begin
			for (int k = 0; k < 4; k++) begin
				buf_mem[AW'(boff) + AW'(k)] <= pwdata[8 * k +: 8];
			end
		end
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			done_reg <= (tick && (q_reg == 2'h3) && (st_reg == H_STOP))
				| (done_reg & ~(apb_wr && (paddr == sbc_pkg::HOST_STAT_OFS)
				&& pwdata[sbc_pkg::HS_DONE]));
			nack_reg <= (byte_end && is_tx && nak_reg)
				| (nack_reg & ~(apb_wr && (paddr == sbc_pkg::HOST_STAT_OFS)
				&& pwdata[sbc_pkg::HS_NACK]));
		end
	end

	// APB read decode; misaligned or unmapped words flag an error
	always_comb begin
		rd_word = 32'h0000_0000;
		err     = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			err = 1'b1;
		end else if (paddr == sbc_pkg::HOST_CTRL_OFS) begin
			rd_word = {8'h00, cnt_reg, idx_reg, 6'h00, rd_reg, 1'b0};
		end else if (paddr == sbc_pkg::HOST_STAT_OFS) begin
			rd_word = {16'h0000, xcnt_reg, 5'h00, done_reg, nack_reg, st_reg != H_IDLE};
		end else if ((paddr >= sbc_pkg::HOST_BUF_OFS) && (boff < 8'(MAX_BYTES))) begin
			for (int k = 0; k < 4; k++) begin
				rd_word[8 * k +: 8] = buf_mem[AW'(boff) + AW'(k)];
			end
		end else begin
			err = 1'b1;
		end
	end

	// Zero-wait answer: everything captured in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= psel && !penable;
			pslverr_reg <= psel && !penable && err;
			prdata_reg  <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	assign prdata             = prdata_reg;
	assign pready             = pready_reg;
	assign pslverr            = pslverr_reg;
	assign link.host_scl_o    = 1'b0;
	assign link.host_sda_o    = 1'b0;
	assign link.host_scl_oe_n = scl_oe_n_reg;
	assign link.host_sda_oe_n = sda_oe_n_reg;

endmodule : sbc_host

// File: sbc_link_chk.sv
// Wire checker for the two-wire link joining host and device ends.
// Assumes the wires are sampled on clk_sys, which also paces the wire clock.
`timescale 1ns/1ps
module sbc_link_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Link wires and data enables
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic       scl_q, sda_q, rd, nk;
	logic [3:0] bp;
	logic [7:0] nb, sh, cnt;
	wire rise = scl & ~scl_q;
	wire st   = scl & scl_q & sda_q & ~sda;  // Start or repeated start
	wire sp   = scl & scl_q & ~sda_q & sda;  // Stop
	wire ack  = rise && bp == 4'h8;          // Ninth clock of a byte
	// Bit and byte position in the segment; rd from the address byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			{scl_q, sda_q} <= 2'h3;
			{bp, nb, rd, nk} <= '0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (st || sp) {bp, nb} <= '0;
			else if (ack) {bp, nb} <= {4'h0, nb + 8'h1};
			else if (rise) bp <= bp + 4'h1;
			if (rise && bp < 4'h8) sh <= {sh[6:0], sda};
			if (ack && nb == 8'h0) rd <= sh[0];
			if (ack && nb == 8'h2) cnt <= sh;
			// Refused read byte: only the stop follows, and the host drives it
			if (st || sp) nk <= 1'b0;
			else if (ack && rd && nb != 8'h0 && sda) nk <= 1'b1;
		end
	end
	// Host answers a device byte with a refusal
	sequence nak_s;
		ack && rd && nb != 8'h0 && sda;
	endsequence
	addr_ack_a: assert property (ack && nb == 8'h0 |-> sh[7:1] == sbc_pkg::DEV_ADDR7 && !sda)
		else $error("address byte wrong or not acknowledged");
	write_ack_a: assert property (ack && nb != 8'h0 && !rd |-> !sda)
		else $error("written byte not acknowledged");
	dev_quiet_a: assert property (rise && bp < 4'h8 && (nb == 8'h0 || !rd) |-> dev_sda_oe_n)
		else $error("device drives data wire during host bits");
	host_quiet_a: assert property (rise && bp < 4'h8 && nb != 8'h0 && rd && !nk
		|-> host_sda_oe_n)
		else $error("host drives data wire during device bits");
	dev_hold_a: assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
		else $error("device changed data wire with clock high");
	host_edge_a: assert property (scl && scl_q && $changed(host_sda_oe_n) |-> st || sp)
		else $error("host changed data wire with clock high outside start or stop");
	// Stop and repeated start each bring one clock rise of their own
	restart_a: assert property (st |-> (bp == 4'h0 && nb == 8'h0)
		|| (bp == 4'h1 && nb == 8'h2 && !rd))
		else $error("repeated start not after address and index");
	stop_len_a: assert property (sp && !rd |-> bp == 4'h1 && nb == cnt + 8'h3)
		else $error("write frame length differs from its count");
	nak_stop_a: assert property (nak_s |=> (dev_sda_oe_n && bp <= 4'h1) until sp)
		else $error("traffic after refusal of a read byte");
	nak_bound_a: assert property (nak_s |-> ##[1:60] sp)
		else $error("no stop after refusal of a read byte");
endmodule : sbc_link_chk

// File: smbus_buffer_control_regs_tb.sv
// Bench: APB-driven host end against the device end, with a register model.
// Assumes the package, the link carrier and both ends are compiled first.
`timescale 1ns/1ps
`define CMP(g, x) begin checks_done++; if ((g) !== (x)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, x); end end
module smbus_buffer_control_regs_tb;
	localparam logic [3:0] REV = 4'h9;   // Arbitrary value
	localparam logic [3:0] VEN = 4'hC;   // Arbitrary value
	localparam logic [7:0] DID = 8'h5E;  // Arbitrary value
	localparam logic [7:0] BUF = sbc_pkg::HOST_BUF_OFS;
	logic        clk_sys = 0, clk_link = 0, rst = 1, bw = 0, lp = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, lbw, lact;
	logic [7:0]  paddr = '0, wb [8], r [8];
	logic [31:0] pwdata = '0, prdata, q;
	logic [3:0]  oen;
	int          mdl [8], fail_count = 0, checks_done = 0, len;
	sbc_link_if link ();
	sbc_host #(.QUARTER_CYC(4)) sbc_host_i (.clk_sys, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link);
	sbc_dev #(.REV_CODE(REV), .VENDOR_CODE(VEN), .DEVICE_CODE(DID)) sbc_dev_i (.clk_link,
		.rst, .link, .pin_bw_high(bw), .pin_loop_on(lp), .loop_bandwidth_select(lbw),
		.loop_active(lact), .out_enable(oen));
	sbc_link_chk sbc_link_chk_i (.clk_sys, .rst, .scl(link.scl), .sda(link.sda),
		.host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n));
	// Two clocks with unrelated phase
	initial forever #25 clk_sys = ~clk_sys;
	initial begin
		#3.3;
		forever #7.5 clk_link = ~clk_link;
	end
	// One APB transfer; waits for pready, bounded
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_sys);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fail_count++;  // No answer counts as a mismatch
		{q, e} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask : apb
	// Block transfer through the host, then compare against the model
	task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] cnt);
		int n = 0;
		len = mdl[5];
		apb(1'b1, BUF, {wb[3], wb[2], wb[1], wb[0]});
		apb(1'b1, BUF + 8'h4, {wb[7], wb[6], wb[5], wb[4]});
		apb(1'b1, sbc_pkg::HOST_CTRL_OFS, {8'h0, cnt, idx, 6'h0, rd, 1'b1});
		do begin apb(1'b0, sbc_pkg::HOST_STAT_OFS, 32'h0); n++; end while (q[2] !== 1'b1 && n < 2000);
		`CMP(q[2:0], 3'h4)
		if (rd) `CMP(q[15:8], 8'(len))
		apb(1'b1, sbc_pkg::HOST_STAT_OFS, 32'h6);
		if (!rd) for (int i = 0; i < cnt; i++) if (idx + i < 3 || idx + i == 5) mdl[idx + i] = wb[i];
		if (rd) begin
			apb(1'b0, BUF, 32'h0);
			{r[3], r[2], r[1], r[0]} = q;
			apb(1'b0, BUF + 8'h4, 32'h0);
			{r[7], r[6], r[5], r[4]} = q;
			for (int i = 0; i < len && i < cnt; i++) `CMP(r[i], (idx + i < 6) ? 8'(mdl[idx + i]) : 8'h0)
		end
		`CMP({lbw, lact}, mdl[0][7] ? {bw, lp} : 2'(mdl[0]))
		`CMP(oen, {mdl[1][5], mdl[1][3], mdl[1][2], mdl[1][0]})
	endtask : xfer
	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	// Hang guard, well past the longest expected run
	initial begin
		#(100000 * 50);
		fail_count++;
		close_out();
	end
	// Defaults, then random control, length and reserved writes with readback
	initial begin
		void'($urandom(32'h82FD));
		mdl = '{8'h83, 8'h2D, 8'h00, {REV, VEN}, DID, 8'h06, 8'h00, 8'h00};
		foreach (wb[i]) wb[i] = 8'h0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		xfer(1'b1, 8'h0, 8'h8);
		for (int t = 0; t < 3; t++) begin
			foreach (wb[i]) wb[i] = 8'($urandom);
			wb[0][7] = 1'(t);  // Pin and register control both used
			wb[3] = 8'h3 + 8'($urandom % 4);  // Readback length 3 to 6
			{bw, lp} <= 2'($urandom);
			xfer(1'b0, 8'h0, 8'h2);
			xfer(1'b0, 8'h2, 8'h5);  // Read-only and unmapped bytes dropped
			xfer(1'b1, 8'h0, 8'h8);
			xfer(1'b1, 8'h4, 8'h4);  // Runs past the last register
		end
		apb(1'b0, 8'h40, 32'h0);
		`CMP({e, q}, {1'b1, 32'h0})
		apb(1'b1, 8'h01, 32'hFFFF_FFFF);
		`CMP(e, 1'b1)
		close_out();
	end
endmodule : smbus_buffer_control_regs_tb
